// file: hw/fltr_fan_loop_regs.sv
// Purpose: Fan loop threshold registers, fail-safe and PWM fan drive
// Assumes: Temperatures arrive in quarter degrees from same-clock logic
// Notes:   Channel 0 remote A drives fan 1, local fan 2, remote B fan 3
//
// Design decision made here: register access over Wishbone.
module fltr_fan_loop_regs (
  input  wire logic       clk,            // 40 MHz clock
  input  wire logic       rstn,           // Synchronous reset, active low
  input  wire logic [9:0] adr_i,          // Wishbone byte address
  input  wire logic [31:0] dat_i,         // Wishbone write data
  output logic      [31:0] dat_o,         // Wishbone read data
  input  wire logic       we_i,           // Wishbone write enable
  input  wire logic [3:0] sel_i,          // Wishbone byte selects
  input  wire logic       cyc_i,          // Wishbone cycle
  input  wire logic       stb_i,          // Wishbone strobe
  output logic            ack_o,          // Wishbone acknowledge
  input  wire logic [9:0] tempRemoteA,    // Remote A reading, 0.25 C steps
  input  wire logic [9:0] tempLocal,      // Local reading, 0.25 C steps
  input  wire logic [9:0] tempRemoteB,    // Remote B reading, 0.25 C steps
  output logic            fan1Pwm,        // Fan 1 pulse-width output
  output logic            fan2Pwm,        // Fan 2 pulse-width output
  output logic            fan3Pwm,        // Fan 3 pulse-width output
  input  wire logic       overtempPinIn,  // Overtemp pin level from pad
  output logic            overtempPinOut, // Overtemp pin drive value
  output logic            overtempPinOe,  // Low while driving the pin
  output logic            treeTestMode    // Tree test mode active
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [11:0] degQ(input logic [7:0] deg);
    degQ = {2'b00, deg, 2'b00};
  endfunction : degQ

  // Reading plus signed offset of half degrees, in quarter degrees
  function automatic logic signed [11:0] corrTemp(input logic [9:0] t,
                                                  input logic [7:0] o);
    corrTemp = $signed({2'b00, t}) + $signed({{3{o[7]}}, o, 1'b0});
  endfunction : corrTemp

  // Minimum duty plus whole degrees above start, scaled by span shift
  function automatic logic [7:0] rampDuty(input logic [7:0] base,
                                          input logic signed [11:0] ex,
                                          input logic [1:0] sh);
    logic [15:0] r;
    logic [15:0] s;
    r = ex[11] ? 16'h0000 : {6'h00, ex[11:2]};
    s = (r << sh) + {8'h00, base};
    rampDuty = (s > 16'h00FF) ? fltr_pkg::DUTY_FULL : s[7:0];
  endfunction : rampDuty

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]         minDutyReg [3];
  logic [7:0]         startReg   [3];
  logic [7:0]         critReg    [3];
  logic [7:0]         offsetReg  [3];
  logic [7:0]         hystLaReg;
  logic [7:0]         hystRbReg;
  logic               treeReg;
  logic [7:0]         ctrlReg;
  logic [2:0]         critState;
  logic [2:0]         fanOn;
  logic [7:0]         divCnt;
  logic [7:0]         pwmCnt;
  logic               pinMeta;
  logic               pinSync;
  logic [9:0]         tempIn   [3];
  logic [3:0]         hyst     [3];
  logic signed [11:0] corr     [3];
  logic [7:0]         dutyNext [3];
  logic [2:0]         overQ;
  logic [2:0]         pwmNext;
  logic [7:0]         rdVal;
  logic [7:0]         idx;
  logic               wrEn;
  logic               autoOn;
  logic               locked;

  assign idx    = adr_i[9:2];
  assign wrEn   = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  assign autoOn = ctrlReg[fltr_pkg::CTRL_AUTO_BIT];
  assign locked = ctrlReg[fltr_pkg::CTRL_LOCK_BIT];
  assign tempIn[0] = tempRemoteA;
  assign tempIn[1] = tempLocal;
  assign tempIn[2] = tempRemoteB;
  // Hysteresis nibbles per channel
  assign hyst[0] = hystLaReg[fltr_pkg::HYST_HI_LSB +: 4];   // [RULE9]
  assign hyst[1] = hystLaReg[fltr_pkg::HYST_LO_LSB +: 4];   // [RULE9]
  assign hyst[2] = hystRbReg[fltr_pkg::HYST_HI_LSB +: 4];   // [RULE9]

  // ---------------------------------------------------------------
  // Wishbone handshake: ack one cycle after request, write on ack
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= {24'h00_0000, rdVal};
    end
  end

  // Read decode; unmapped indices read zero
  always_comb begin
    rdVal = 8'h00;
    case (idx)
      fltr_pkg::IDX_MIN_DUTY1:    rdVal = minDutyReg[0];
      fltr_pkg::IDX_MIN_DUTY2:    rdVal = minDutyReg[1];
      fltr_pkg::IDX_MIN_DUTY3:    rdVal = minDutyReg[2];
      fltr_pkg::IDX_START_RA:     rdVal = startReg[0];
      fltr_pkg::IDX_START_LOCAL:  rdVal = startReg[1];
      fltr_pkg::IDX_START_RB:     rdVal = startReg[2];
      fltr_pkg::IDX_CRIT_RA:      rdVal = critReg[0];
      fltr_pkg::IDX_CRIT_LOCAL:   rdVal = critReg[1];
      fltr_pkg::IDX_CRIT_RB:      rdVal = critReg[2];
      fltr_pkg::IDX_HYST_LA:      rdVal = hystLaReg;
      fltr_pkg::IDX_HYST_RB:      rdVal = hystRbReg;
      fltr_pkg::IDX_TREE:         rdVal = {7'h00, treeReg};
      fltr_pkg::IDX_OFFSET_RA:    rdVal = offsetReg[0];
      fltr_pkg::IDX_OFFSET_LOCAL: rdVal = offsetReg[1];
      fltr_pkg::IDX_OFFSET_RB:    rdVal = offsetReg[2];
      fltr_pkg::IDX_CTRL:         rdVal = ctrlReg;
      fltr_pkg::IDX_STATUS:       rdVal = {treeReg, pinSync, critState,
                                           fanOn};
      default:                    rdVal = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Minimum duty: frozen while the automatic loop owns the fans
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        minDutyReg[i] <= fltr_pkg::RST_MIN_DUTY;             // [RULE1]
      end
    end else if (wrEn && !autoOn) begin                      // [RULE3]
      case (idx)
        fltr_pkg::IDX_MIN_DUTY1: minDutyReg[0] <= dat_i[7:0];
        fltr_pkg::IDX_MIN_DUTY2: minDutyReg[1] <= dat_i[7:0];
        fltr_pkg::IDX_MIN_DUTY3: minDutyReg[2] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Start temperatures are never locked
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        startReg[i] <= fltr_pkg::RST_START;                  // [RULE4]
      end
    end else if (wrEn) begin
      case (idx)
        fltr_pkg::IDX_START_RA:    startReg[0] <= dat_i[7:0];
        fltr_pkg::IDX_START_LOCAL: startReg[1] <= dat_i[7:0];
        fltr_pkg::IDX_START_RB:    startReg[2] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Lockable group; a locked write is acked but dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        critReg[i]   <= fltr_pkg::RST_CRIT;                  // [RULE5]
        offsetReg[i] <= fltr_pkg::RST_OFFSET;                // [RULE14]
      end
      hystLaReg <= fltr_pkg::RST_HYST_LA;                    // [RULE9]
      hystRbReg <= fltr_pkg::RST_HYST_RB;                    // [RULE9]
      treeReg   <= fltr_pkg::RST_TREE;                       // [RULE13]
    end else if (wrEn && !locked) begin                      // [RULE12]
      case (idx)
        fltr_pkg::IDX_CRIT_RA:      critReg[0]   <= dat_i[7:0];
        fltr_pkg::IDX_CRIT_LOCAL:   critReg[1]   <= dat_i[7:0];
        fltr_pkg::IDX_CRIT_RB:      critReg[2]   <= dat_i[7:0];
        fltr_pkg::IDX_HYST_LA:      hystLaReg    <= dat_i[7:0];
        fltr_pkg::IDX_HYST_RB:      hystRbReg    <= dat_i[7:0];
        fltr_pkg::IDX_TREE:
          treeReg <= dat_i[fltr_pkg::TREE_EN_BIT];           // [RULE13]
        fltr_pkg::IDX_OFFSET_RA:    offsetReg[0] <= dat_i[7:0];
        fltr_pkg::IDX_OFFSET_LOCAL: offsetReg[1] <= dat_i[7:0];
        fltr_pkg::IDX_OFFSET_RB:    offsetReg[2] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Control: lock is set-only so a hung host cannot unlock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlReg <= fltr_pkg::RST_CTRL;
    end else if (wrEn && idx == fltr_pkg::IDX_CTRL) begin
      ctrlReg <= dat_i[7:0] | {6'h00, locked, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Temperature compare and loop state
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      corr[i]  = corrTemp(tempIn[i], offsetReg[i]);          // [RULE14]
      overQ[i] = (critReg[i] != fltr_pkg::CRIT_DISABLE) &&
                 (corr[i] > degQ(critReg[i]));               // [RULE8]
    end
  end

  // Critical latch with hysteresis on the corrected reading
  always_ff @(posedge clk) begin
    if (!rstn) begin
      critState <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (critReg[i] == fltr_pkg::CRIT_DISABLE) begin      // [RULE6]
          critState[i] <= 1'b0;
        end else if (corr[i] > degQ(critReg[i])) begin       // [RULE15]
          critState[i] <= 1'b1;                              // [RULE5]
        end else if (corr[i] <
                     degQ(critReg[i]) - degQ({4'h0, hyst[i]})) begin
          critState[i] <= 1'b0;                              // [RULE7]
        end
      end
    end
  end

  // Fan start latch: on above start, off at start minus hysteresis
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fanOn <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (corr[i] > degQ(startReg[i])) begin               // [RULE4]
          fanOn[i] <= 1'b1;
        end else if (corr[i] <=
                     degQ(startReg[i]) - degQ({4'h0, hyst[i]})) begin
          fanOn[i] <= 1'b0;                                  // [RULE10]
        end
      end
    end
  end

  // Duty choice: fail-safe first, then loop, else fixed minimum
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (|critState) begin
        dutyNext[i] = fltr_pkg::DUTY_FULL;                   // [RULE5]
      end else if (autoOn) begin
        dutyNext[i] = fanOn[i] ?
          rampDuty(minDutyReg[i], corr[i] - degQ(startReg[i]),
                   ctrlReg[fltr_pkg::CTRL_SPAN_LSB +: 2]) :
          fltr_pkg::DUTY_OFF;                                // [RULE10]
      end else begin
        dutyNext[i] = minDutyReg[i];
      end
      // Full code bypasses the compare so 0xFF is truly 100 percent
      pwmNext[i] = (dutyNext[i] == fltr_pkg::DUTY_FULL) ||
                   (pwmCnt < dutyNext[i]);                   // [RULE2]
    end
  end

  // ---------------------------------------------------------------
  // PWM timebase and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt <= 8'h00;
      pwmCnt <= 8'h00;
    end else if (divCnt == fltr_pkg::PWM_DIV - 8'h01) begin
      divCnt <= 8'h00;
      pwmCnt <= (pwmCnt == fltr_pkg::PWM_LAST) ? 8'h00 : pwmCnt + 8'h01;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {fan3Pwm, fan2Pwm, fan1Pwm} <= 3'b000;
    end else begin
      {fan3Pwm, fan2Pwm, fan1Pwm} <= pwmNext;
    end
  end

  // Open-drain overtemp pin and its input synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overtempPinOut <= 1'b1;
      overtempPinOe  <= 1'b1;
      pinMeta        <= 1'b1;
      pinSync        <= 1'b1;
      treeTestMode   <= 1'b0;
    end else begin
      overtempPinOut <= ~(ctrlReg[fltr_pkg::CTRL_PIN_BIT] & |overQ);
      overtempPinOe  <= ~(ctrlReg[fltr_pkg::CTRL_PIN_BIT] & |overQ);
      pinMeta        <= overtempPinIn;
      pinSync        <= pinMeta;
      treeTestMode   <= treeReg;                             // [RULE13]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_reset_vals;
    @(posedge clk) !rstn |=> minDutyReg[1] == 8'h80 &&
      startReg[1] == 8'h5A && critReg[2] == 8'h64 && hystLaReg == 8'h44
      && hystRbReg == 8'h40 && offsetReg[0] == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) // [RULE1] [RULE4] [RULE9]
    else $error("register reset value wrong");

  property p_auto_ro;
    @(posedge clk) disable iff (!rstn)
    wrEn && autoOn && idx == fltr_pkg::IDX_MIN_DUTY1
      |=> $stable(minDutyReg[0]);
  endproperty
  a_auto_ro: assert property (p_auto_ro) // [RULE3]
    else $error("minimum duty written in automatic mode");

  property p_lock_ro;
    @(posedge clk) disable iff (!rstn)
    wrEn && locked && idx == fltr_pkg::IDX_OFFSET_RB
      |=> $stable(offsetReg[2]) && $stable(critReg[2]);
  endproperty
  a_lock_ro: assert property (p_lock_ro) // [RULE12]
    else $error("locked register changed");

  property p_crit_full;
    @(posedge clk) disable iff (!rstn)
    |critState |=> fan1Pwm && fan2Pwm && fan3Pwm;
  endproperty
  a_crit_full: assert property (p_crit_full) // [RULE5] [RULE2]
    else $error("fans not at full duty under critical state");

  property p_crit_dis;
    @(posedge clk) disable iff (!rstn)
    critReg[1] == 8'h80 |=> !critState[1];
  endproperty
  a_crit_dis: assert property (p_crit_dis) // [RULE6]
    else $error("disabled limit still forces full speed");

  property p_crit_hold;
    @(posedge clk) disable iff (!rstn)
    critState[0] && critReg[0] != 8'h80 &&
      corr[0] >= degQ(critReg[0]) - degQ({4'h0, hyst[0]})
      |=> critState[0];
  endproperty
  a_crit_hold: assert property (p_crit_hold) // [RULE7] [RULE15]
    else $error("critical state released inside hysteresis");

  property p_pin_low;
    @(posedge clk) disable iff (!rstn)
    ctrlReg[2] && critReg[1] != 8'h80 && corr[1] == degQ(critReg[1]) + 1
      |=> !overtempPinOe && !overtempPinOut;
  endproperty
  a_pin_low: assert property (p_pin_low) // [RULE8]
    else $error("overtemp pin not driven low");

  property p_fan_hold;
    @(posedge clk) disable iff (!rstn)
    fanOn[2] && corr[2] > degQ(startReg[2]) - degQ({4'h0, hyst[2]})
      |=> fanOn[2];
  endproperty
  a_fan_hold: assert property (p_fan_hold) // [RULE10]
    else $error("fan stopped inside hysteresis band");

  property p_duty_off;
    @(posedge clk) disable iff (!rstn)
    dutyNext[0] == 8'h00 |=> !fan1Pwm;
  endproperty
  a_duty_off: assert property (p_duty_off) // [RULE2]
    else $error("zero duty produced a pulse");

  property p_offset_start;
    @(posedge clk) disable iff (!rstn)
    $signed({2'b00, tempLocal}) + $signed({{3{offsetReg[1][7]}},
      offsetReg[1], 1'b0}) > degQ(startReg[1]) |=> fanOn[1];
  endproperty
  a_offset_start: assert property (p_offset_start) // [RULE14] [RULE4]
    else $error("corrected reading above start left fan off");

  property p_tree;
    @(posedge clk) disable iff (!rstn)
    wrEn && !locked && idx == fltr_pkg::IDX_TREE
      |=> ##1 treeTestMode == $past(dat_i[0], 2);
  endproperty
  a_tree: assert property (p_tree) // [RULE13]
    else $error("tree test mode does not follow bit 0");
endmodule : fltr_fan_loop_regs

// file: hw/fltr_pkg.sv
// Purpose: Constants for the fan loop threshold register bank
// Assumes: Register index times four is the Wishbone byte address
// Notes:   Function
// Function
// [RULE1] Three 8-bit minimum duty registers, one per fan, reset to half duty.
// [RULE2] Duty code 0x00 is off, 0x40 quarter, 0xFF full speed.
// [RULE3] Minimum duty registers ignore writes while the automatic loop runs.
// [RULE4] Per-channel fan start temperature, reset 90 degrees, starts ramp above.
// [RULE5] Per-channel critical limit, reset 100; any exceed forces all fans full.
// [RULE6] A critical limit of 0x80 disables that channel's fail-safe.
// [RULE7] Forced full duty holds until temperature drops below limit minus hysteresis.
// [RULE8] Configured as output, the overtemp pin goes low a quarter degree over.
// [RULE9] Hysteresis nibbles: local 3:0, remote A 7:4 (0x44), remote B 7:4 (0x40).
// [RULE10] Below start, fan keeps minimum duty until start minus hysteresis.
// [RULE11] Software should program hysteresis of at least four degrees.
// [RULE12] Lock makes limit, hysteresis, test and offset registers read-only.
// [RULE13] Bit 0 of the test register enters tree test mode; reset zero.
// [RULE14] Signed half-degree offset per channel is added to its reading.
// [RULE15] Offset-corrected temperature is compared against every threshold.
package fltr_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_MIN_DUTY1    = 8'h64;
  localparam logic [7:0] IDX_MIN_DUTY2    = 8'h65;
  localparam logic [7:0] IDX_MIN_DUTY3    = 8'h66;
  localparam logic [7:0] IDX_START_RA     = 8'h67;
  localparam logic [7:0] IDX_START_LOCAL  = 8'h68;
  localparam logic [7:0] IDX_START_RB     = 8'h69;
  localparam logic [7:0] IDX_CRIT_RA      = 8'h6A;
  localparam logic [7:0] IDX_CRIT_LOCAL   = 8'h6B;
  localparam logic [7:0] IDX_CRIT_RB      = 8'h6C;
  localparam logic [7:0] IDX_HYST_LA      = 8'h6D;
  localparam logic [7:0] IDX_HYST_RB      = 8'h6E;
  localparam logic [7:0] IDX_TREE         = 8'h6F;
  localparam logic [7:0] IDX_OFFSET_RA    = 8'h70;
  localparam logic [7:0] IDX_OFFSET_LOCAL = 8'h71;
  localparam logic [7:0] IDX_OFFSET_RB    = 8'h72;
  localparam logic [7:0] IDX_CTRL         = 8'h60;
  localparam logic [7:0] IDX_STATUS       = 8'h61;
  // ---------------------------------------------------------------
  // Reset values and special codes
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MIN_DUTY = 8'h80;
  localparam logic [7:0] RST_START    = 8'h5A;
  localparam logic [7:0] RST_CRIT     = 8'h64;
  localparam logic [7:0] RST_HYST_LA  = 8'h44;
  localparam logic [7:0] RST_HYST_RB  = 8'h40;
  localparam logic       RST_TREE     = 1'b0;
  localparam logic [7:0] RST_OFFSET   = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] CRIT_DISABLE = 8'h80;
  localparam logic [7:0] DUTY_OFF     = 8'h00;
  localparam logic [7:0] DUTY_FULL    = 8'hFF;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HYST_HI_LSB   = 4;
  localparam int HYST_LO_LSB   = 0;
  localparam int TREE_EN_BIT   = 0;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam int CTRL_PIN_BIT  = 2;
  localparam int CTRL_SPAN_LSB = 4;
  // ---------------------------------------------------------------
  // Timing: PWM counter advances once per PWM_DIV clocks
  // ---------------------------------------------------------------
  localparam logic [7:0] PWM_DIV     = 8'h10;
  localparam logic [7:0] PWM_LAST    = 8'hFE;
endpackage : fltr_pkg

// file: verification/fltr_fan_loop_regs_tb_top.sv
// Purpose: Self-checking bench for the fan loop threshold registers
// Assumes: One register per word, byte address is index times four
// Notes: Hysteresis stays at four degrees throughout
module fltr_fan_loop_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        clk, rstn, we, cyc, stb, ack, pinOut, pinOe, pinLevel, tree;
  logic [9:0]  adr, tA, tL, tB;
  logic [31:0] wdat, rdat;
  logic [3:0]  sel;
  logic [2:0]  fans;
  logic [7:0]  rd;
  int          err_total, total_checks, cycles;
  fltr_fan_loop_regs i_fltr_fan_loop_regs (.clk(clk), .rstn(rstn),
    .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .tempRemoteA(tA),
    .tempLocal(tL), .tempRemoteB(tB), .fan1Pwm(fans[0]),
    .fan2Pwm(fans[1]), .fan3Pwm(fans[2]), .overtempPinIn(pinLevel),
    .overtempPinOut(pinOut), .overtempPinOe(pinOe), .treeTestMode(tree));
  fltr_sensor_model i_fltr_sensor_model (.pinOut(pinOut), .pinOe(pinOe),
    .tempA(tA), .tempL(tL), .tempB(tB), .pinLevel(pinLevel));
  always #12.5 clk = ~clk;
  // Hang guard: the whole run needs about 12600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Classic cycle; the request holds until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  // Settle after a write so latches and PWM outputs follow
  task automatic wr(input logic [7:0] idx, d);
    xfer(1'b1, idx, d);
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic rchk(input logic [7:0] idx, exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rchk
  task automatic temps(input logic [9:0] a, l, b);
    @(posedge clk);
    i_fltr_sensor_model.set_temps(a, l, b);
    repeat (4) @(posedge clk);
  endtask : temps
  function automatic logic [7:0] rst_val(input int i);
    return i < 8'h67 ? 8'h80 : i < 8'h6A ? 8'h5A : i < 8'h6D ? 8'h64 :
           i == 8'h6D ? 8'h44 : i == 8'h6E ? 8'h40 : 8'h00;
  endfunction : rst_val
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    for (int i = 8'h64; i <= 8'h72; i++) begin
      rchk(8'(i), rst_val(i));
    end
    rchk(8'h7F, 8'h00);
    chk(tree, 1'b0);
    $display("test_reset done");
  endtask : test_reset
  // One full PWM period counts exactly code times divider highs
  task automatic test_duty;
    logic [7:0] c;
    int         hi;
    for (int k = 0; k < 3; k++) begin
      c = k == 0 ? 8'h00 : k == 1 ? 8'h40 : 8'hFF;
      wr(fltr_pkg::IDX_MIN_DUTY1, c);
      hi = 0;
      repeat (255 * fltr_pkg::PWM_DIV) begin
        @(posedge clk);
        hi += (fans[0] === 1'b1);
      end
      chk(hi, (c == 8'hFF ? 255 : c) * fltr_pkg::PWM_DIV);
    end
    $display("test_duty done");
  endtask : test_duty
  task automatic test_crit;
    for (int i = 8'h64; i <= 8'h66; i++) wr(8'(i), 8'h00);
    wr(fltr_pkg::IDX_CTRL, 8'h04);
    temps(10'd396, 10'd200, 10'd200);
    chk({fans, pinOe}, 4'b0001);
    wr(fltr_pkg::IDX_OFFSET_RA, 8'h04);
    chk(fans, 3'b111);
    chk({pinOe, pinOut, pinLevel}, 3'b000);
    rchk(fltr_pkg::IDX_STATUS, 8'h09);
    wr(fltr_pkg::IDX_OFFSET_RA, 8'h00);
    temps(10'd390, 10'd200, 10'd200);
    chk(fans, 3'b111);
    temps(10'd380, 10'd200, 10'd200);
    chk(fans, 3'b000);
    wr(fltr_pkg::IDX_CRIT_LOCAL, fltr_pkg::CRIT_DISABLE);
    temps(10'd200, 10'd1000, 10'd200);
    chk({fans, pinOe}, 4'b0001);
    temps(10'd200, 10'd200, 10'd200);
    $display("test_crit done");
  endtask : test_crit
  task automatic test_start;
    wr(fltr_pkg::IDX_MIN_DUTY1, 8'hFF);
    wr(fltr_pkg::IDX_CTRL, 8'h01);
    wr(fltr_pkg::IDX_MIN_DUTY1, 8'h11);
    rchk(fltr_pkg::IDX_MIN_DUTY1, 8'hFF);
    temps(10'd340, 10'd200, 10'd200);
    chk(fans, 3'b000);
    temps(10'd364, 10'd200, 10'd200);
    chk(fans, 3'b001);
    temps(10'd350, 10'd200, 10'd200);
    chk(fans, 3'b001);
    temps(10'd340, 10'd200, 10'd200);
    chk(fans, 3'b000);
    wr(fltr_pkg::IDX_CTRL, 8'h00);
    $display("test_start done");
  endtask : test_start
  task automatic test_lock;
    wr(fltr_pkg::IDX_TREE, 8'h01);
    chk(tree, 1'b1);
    wr(fltr_pkg::IDX_TREE, 8'h00);
    chk(tree, 1'b0);
    wr(fltr_pkg::IDX_CTRL, 8'h02);
    for (int i = 8'h6A; i <= 8'h72; i++) begin
      wr(8'(i), 8'h01);
      rchk(8'(i), i == 8'h6B ? 8'h80 : rst_val(i));
    end
    chk(tree, 1'b0);
    $display("test_lock done");
  endtask : test_lock
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we} = 3'b000;
    adr = 10'h000;
    wdat = 32'h00000000;
    sel = 4'hF;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_duty();
    test_crit();
    test_start();
    test_lock();
    report_and_stop();
  end
endmodule : fltr_fan_loop_regs_tb_top

// file: verification/fltr_sensor_model.sv
// Purpose: Sensor and pad model on the far side of the threshold bank
// Assumes: Readings are quarter degrees on the block clock
// Notes:   Pad has a pull-up, so a released pin reads high
module fltr_sensor_model (
  input  wire logic       pinOut,  // Pin drive value from block
  input  wire logic       pinOe,   // Low while block drives pin
  output logic      [9:0] tempA,   // Remote A reading
  output logic      [9:0] tempL,   // Local reading
  output logic      [9:0] tempB,   // Remote B reading
  output logic            pinLevel // Resolved pad level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Pad and readings
  // ------------------------------------------------------------
  // Pull-up wins whenever the open-drain pin is released
  assign pinLevel = (!pinOe && !pinOut) ? 1'b0 : 1'b1;
  // Readings hold like a finished conversion until updated
  initial begin
    tempA = 10'h0C8;
    tempL = 10'h0C8;
    tempB = 10'h0C8;
  end
  task automatic set_temps(input logic [9:0] a, l, b);
    tempA <= a;
    tempL <= l;
    tempB <= b;
  endtask : set_temps
endmodule : fltr_sensor_model
